/* include/adcseq_pkg.sv */
`default_nettype none
package adcseq_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL_A = 8'h00;
  localparam logic [7:0] ADR_CTRL_B = 8'h04;
  localparam logic [7:0] ADR_PIN_EN = 8'h08;
  localparam logic [7:0] ADR_RES_LO = 8'h0C;
  localparam logic [7:0] ADR_RES_HI = 8'h10;
  localparam logic [7:0] ADR_IRQ_STS = 8'h14;
  localparam logic [7:0] ADR_IRQ_MSK = 8'h18;
  localparam logic [7:0] ADR_IRQ_GLB = 8'h1C;
  // converter_ctrl_a fields
  localparam int CA_CHAN_LO = 0;
  localparam int CA_POWER_DOWN = 4;
  localparam int CA_PENDING = 6;
  localparam int CA_START = 7;
  // converter_ctrl_b fields
  localparam int CB_CLK_SEL = 0;
  localparam int CB_CHAN_HI = 4;
  localparam int CB_REF_SEL = 5;
  // reset values
  localparam logic RST_POWER_DOWN = 1'b1;
  localparam logic [2:0] RST_CLK_SEL = 3'h0;
  // conversion timing in conversion-clock periods, then result width and codes and divider width
  localparam logic [3:0] CONV_PERIODS_M1 = 4'hF;
  localparam logic [3:0] SAMPLE_LAST = 4'h1;
  localparam logic [3:0] BIT_FIRST = 4'h2;
  localparam logic [3:0] BIT_LAST = 4'hD;
  localparam int RES_BITS = 12;
  localparam logic [11:0] RES_FULL_SCALE = 12'hFFF;
  localparam logic [11:0] RES_MSB = 12'h800;
  localparam int DIV_BITS = 7;

  typedef enum logic [1:0] {
    ADCSEQ_IDLE = 2'b00,
    ADCSEQ_ARMED = 2'b01,
    ADCSEQ_CONV = 2'b10
  } adcseq_state_t;

  typedef struct packed {
    logic power_en;
    logic [2:0] channel;
    logic [3:0] pin_analog;
    logic ref_from_pin;
    logic sample_hold;
    logic [11:0] dac_code;
  } adcseq_ana_t;
endpackage
`default_nettype wire

/* core/adcseq_top.sv */
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none
module adcseq_top
  import adcseq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmp_in,
  output adcseq_ana_t ana_o,
  output logic irq_o
);

  function automatic logic [DIV_BITS-1:0] div_mask(input logic [2:0] sel);
    div_mask = DIV_BITS'((8'h01 << sel) - 8'h01);
  endfunction

  // shared address compare for every register write strobe
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] target);
    reg_hit = (adr == target);
  endfunction

  logic ack_q;
  logic [31:0] dat_q;
  logic [1:0] chan_lo_q;
  logic chan_hi_q;
  logic power_down_q;
  logic start_q;
  logic start_prev_q;
  logic [2:0] clk_sel_q;
  logic ref_sel_q;
  logic [3:0] pin_en_q;
  logic [11:0] result_q;
  logic irq_flag_q;
  logic irq_msk_q;
  logic irq_glb_q;
  logic [DIV_BITS-1:0] div_q;
  logic tick;
  adcseq_state_t state_q;
  logic [3:0] period_q;
  logic [11:0] trial_q;
  logic [11:0] bit_q;
  logic cmp_meta_q;
  logic cmp_sync_q;
  logic done;
  logic wr_en;
  logic req;
  logic [31:0] rd_data;
  logic start_rise;
  logic start_fall;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_pin_en;
  logic wr_irq_sts;
  logic wr_irq_msk;
  logic wr_irq_glb;

  // bus writes take effect on the edge that the master samples ack
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign wr_ctrl_a = wr_en & reg_hit(wb_adr_i, ADR_CTRL_A);
  assign wr_ctrl_b = wr_en & reg_hit(wb_adr_i, ADR_CTRL_B);
  assign wr_pin_en = wr_en & reg_hit(wb_adr_i, ADR_PIN_EN);
  assign wr_irq_sts = wr_en & reg_hit(wb_adr_i, ADR_IRQ_STS);
  assign wr_irq_msk = wr_en & reg_hit(wb_adr_i, ADR_IRQ_MSK);
  assign wr_irq_glb = wr_en & reg_hit(wb_adr_i, ADR_IRQ_GLB);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CTRL_A: begin
        rd_data[CA_CHAN_LO +: 2] = chan_lo_q;
        rd_data[CA_POWER_DOWN] = power_down_q;
        rd_data[CA_PENDING] = (state_q != ADCSEQ_IDLE);
        rd_data[CA_START] = start_q;
      end
      ADR_CTRL_B: begin
        rd_data[CB_CLK_SEL +: 3] = clk_sel_q;
        rd_data[CB_CHAN_HI] = chan_hi_q;
        rd_data[CB_REF_SEL] = ref_sel_q;
      end
      ADR_PIN_EN: rd_data[3:0] = pin_en_q;
      ADR_RES_LO: rd_data[7:0] = result_q[7:0];
      ADR_RES_HI: rd_data[3:0] = result_q[11:8];
      ADR_IRQ_STS: rd_data[0] = irq_flag_q;
      ADR_IRQ_MSK: rd_data[0] = irq_msk_q;
      ADR_IRQ_GLB: rd_data[0] = irq_glb_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~ack_q & ~wb_we_i) begin
      dat_q <= rd_data;
    end
  end

  // control registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_lo_q <= 2'h0;
      power_down_q <= RST_POWER_DOWN;
      start_q <= 1'b0;
    end else if (wr_ctrl_a) begin
      chan_lo_q <= wb_dat_i[CA_CHAN_LO +: 2];
      power_down_q <= wb_dat_i[CA_POWER_DOWN];
      start_q <= wb_dat_i[CA_START];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_q <= RST_CLK_SEL;
      chan_hi_q <= 1'b0;
      ref_sel_q <= 1'b0;
    end else if (wr_ctrl_b) begin
      clk_sel_q <= wb_dat_i[CB_CLK_SEL +: 3];
      chan_hi_q <= wb_dat_i[CB_CHAN_HI];
      ref_sel_q <= wb_dat_i[CB_REF_SEL];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_en_q <= 4'h0;
    end else if (wr_pin_en) begin
      pin_en_q <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_msk_q <= 1'b0;
      irq_glb_q <= 1'b0;
    end else if (wr_en) begin
      if (wr_irq_msk) begin
        irq_msk_q <= wb_dat_i[0];
      end
      if (wr_irq_glb) begin
        irq_glb_q <= wb_dat_i[0];
      end
    end
  end

  // conversion clock: one-cycle enable every 2^sel system clocks; sel 7 gives /128
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (power_down_q || state_q != ADCSEQ_CONV) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_BITS'(1);
    end
  end
  assign tick = (div_q & div_mask(clk_sel_q)) == div_mask(clk_sel_q);

  // comparator comes from the analog domain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_q;
    end
  end
  assign start_rise = start_q & ~start_prev_q;
  assign start_fall = ~start_q & start_prev_q;

  assign done = (state_q == ADCSEQ_CONV) && tick && (period_q == CONV_PERIODS_M1);

  // sequencer; a new rising start edge aborts whatever is running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ADCSEQ_IDLE;
      period_q <= 4'h0;
    end else if (power_down_q) begin
      state_q <= ADCSEQ_IDLE;
      period_q <= 4'h0;
    end else if (start_rise) begin
      state_q <= ADCSEQ_ARMED;
      period_q <= 4'h0;
    end else begin
      case (state_q)
        ADCSEQ_IDLE: period_q <= 4'h0;
        ADCSEQ_ARMED: begin
          if (start_fall) begin
            state_q <= ADCSEQ_CONV;
          end
        end
        ADCSEQ_CONV: begin
          if (tick) begin
            period_q <= period_q + 4'h1;
            if (done) begin
              state_q <= ADCSEQ_IDLE;
            end
          end
        end
        default: state_q <= ADCSEQ_IDLE;
      endcase
    end
  end

  // successive approximation, msb first, one bit per conversion-clock period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trial_q <= 12'h000;
      bit_q <= 12'h000;
    end else if (power_down_q || start_rise || state_q != ADCSEQ_CONV) begin
      trial_q <= 12'h000;
      bit_q <= 12'h000;
    end else if (tick) begin
      if (period_q == SAMPLE_LAST) begin
        trial_q <= RES_MSB;
        bit_q <= RES_MSB;
      end else if (period_q >= BIT_FIRST && period_q <= BIT_LAST) begin
        // input below the trial level drops the bit under test
        trial_q <= (cmp_sync_q ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
        bit_q <= bit_q >> 1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= 12'h000;
    end else if (done) begin
      result_q <= trial_q & RES_FULL_SCALE;
    end
  end

  // set wins over a simultaneous write-one clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_q <= 1'b0;
    end else if (done) begin
      irq_flag_q <= 1'b1;
    end else if (wr_irq_sts && wb_dat_i[0]) begin
      irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_flag_q & irq_msk_q & irq_glb_q;
    end
  end

  // analog controls are registered so the front end sees no glitches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ana_o <= '0;
    end else begin
      ana_o.power_en <= ~power_down_q;
      ana_o.channel <= {chan_hi_q, chan_lo_q};
      ana_o.pin_analog <= pin_en_q;
      ana_o.ref_from_pin <= ref_sel_q;
      ana_o.sample_hold <= (state_q == ADCSEQ_CONV) && (period_q <= SAMPLE_LAST);
      ana_o.dac_code <= trial_q;
    end
  end

endmodule
`default_nettype wire

/* bench/adcseq_top_assertions.sv */
`default_nettype none
module adcseq_top_assertions
  import adcseq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cmp_in,
  input wire adcseq_ana_t ana_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a write lands at the ack edge; ana_o and irq_o follow one register later
  sequence wr_s(logic [7:0] a);
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
  endsequence
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a:
    assert property (req_s |=> wb_ack_o) else $error("request not acked");
  power_map_a:
    assert property (wr_s(ADR_CTRL_A) |-> ##2 ana_o.power_en == !$past(wb_dat_i[4], 2))
    else $error("power enable wrong");
  chan_map_a:
    assert property (wr_s(ADR_CTRL_A) |-> ##2 ana_o.channel[1:0] == $past(wb_dat_i[1:0], 2))
    else $error("channel low wrong");
  pin_map_a:
    assert property (wr_s(ADR_PIN_EN) |-> ##2 ana_o.pin_analog == $past(wb_dat_i[3:0], 2))
    else $error("pin enables wrong");
  glb_gate_a:
    assert property (wr_s(ADR_IRQ_GLB) ##0 !wb_dat_i[0] |-> ##2 !irq_o)
    else $error("irq without global enable");
  msk_gate_a:
    assert property (wr_s(ADR_IRQ_MSK) ##0 !wb_dat_i[0] |-> ##2 !irq_o)
    else $error("irq without converter enable");
  hold_two_a:
    assert property ($rose(ana_o.sample_hold) |-> ana_o.sample_hold[*2])
    else $error("sample phase too short");
  trial_msb_a:
    assert property ($fell(ana_o.sample_hold) |-> ana_o.dac_code == RES_MSB)
    else $error("first trial code not half scale");
endmodule
bind adcseq_top adcseq_top_assertions u_chk (.mclk(mclk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cmp_in(cmp_in), .ana_o(ana_o), .irq_o(irq_o));
`default_nettype wire

/* bench/test_adcseq_top.sv */
`default_nettype none
module test_adcseq_top
  import adcseq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, x, s) begin comparisons++; if ((s) !== (x)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, x, s); end end
  logic mclk = 1'b0;
  logic rst_n, cyc, stb, we, ack, cmp, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, r, p, c;
  adcseq_ana_t ana;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [11:0] vin = 12'h000;
  logic track = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed, n;
  always #5 mclk = ~mclk;
  // comparator: with track set, high while the held input is at or above the trial level, else c[0]
  always @(posedge mclk) cmp <= track ? (vin >= ana.dac_code) : c[0];
  adcseq_top dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmp_in(cmp), .ana_o(ana), .irq_o(irq));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h1;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back({1'b1, x});
    bus(1'b0, a, 32'h0);
  endtask
  // polling reads carry no expectation, the caller judges r itself
  task automatic peek(input logic [7:0] a);
    q.push_back(33'h0);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk);
  endtask
  task automatic start;
    wr(ADR_CTRL_A, {24'h0, 6'h20, p[6:5]});
    wr(ADR_CTRL_A, {30'h0, p[6:5]});
  endtask
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      if (e[32]) `CHK("rdata", e[31:0], rdat)
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    seed = 32'hf2f0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'h0;
    dat = 32'h0;
    c = 32'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ADR_CTRL_A, 32'h10);
    rd(ADR_CTRL_B, 32'h0);
    rd(8'h20, 32'h0);
    wr(ADR_CTRL_A, 32'h90);
    wr(ADR_CTRL_A, 32'h10);
    rd(ADR_CTRL_A, 32'h10);
    settle;
    `CHK("power_en", 1'b0, ana.power_en)
    $display("test power_down done");
    p = $random(seed);
    wr(ADR_PIN_EN, {28'h0, p[3:0]});
    wr(ADR_CTRL_B, {26'h0, 1'b1, p[4], 4'h0});
    wr(ADR_CTRL_A, {30'h0, p[6:5]});
    settle;
    `CHK("channel", {p[4], p[6:5]}, ana.channel)
    `CHK("pins", p[3:0], ana.pin_analog)
    `CHK("ref_pin", 1'b1, ana.ref_from_pin)
    `CHK("power_en", 1'b1, ana.power_en)
    $display("test routing done");
    wr(ADR_IRQ_MSK, 32'h1);
    wr(ADR_IRQ_GLB, 32'h1);
    for (int s = 0; s < 8; s++) begin
      c = $random(seed);
      // comparator held for the whole conversion, so the code is all ones or all zeros
      wr(ADR_CTRL_B, {26'h0, 1'b1, p[4], 1'b0, s[2:0]});
      start;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge mclk);
        n++;
      end
      `CHK("conv_len", 1'b1, n >= (16 << s) && n <= (16 << s) + 4)
      rd(ADR_IRQ_STS, 32'h1);
      rd(ADR_RES_LO, {24'h0, {8{c[0]}}});
      rd(ADR_RES_HI, {28'h0, {4{c[0]}}});
      rd(ADR_CTRL_A, {30'h0, p[6:5]});
      wr(ADR_IRQ_STS, 32'h1);
      settle;
      `CHK("irq_clear", 1'b0, irq)
    end
    $display("test timing done");
    wr(ADR_IRQ_MSK, 32'h0);
    // divide by 8 leaves the comparator path time to settle before each decision
    wr(ADR_CTRL_B, {26'h0, 1'b1, p[4], 4'h3});
    c = $random(seed);
    vin = c[11:0];
    track = 1'b1;
    start;
    peek(ADR_CTRL_A);
    `CHK("pending", 1'b1, r[CA_PENDING])
    n = 0;
    while (r[CA_PENDING] !== 1'b0 && n < 100) begin
      peek(ADR_CTRL_A);
      n++;
    end
    `CHK("pending", 1'b0, r[CA_PENDING])
    rd(ADR_RES_LO, {24'h0, vin[7:0]});
    rd(ADR_RES_HI, {28'h0, vin[11:8]});
    `CHK("irq_masked", 1'b0, irq)
    rd(ADR_IRQ_STS, 32'h1);
    wr(ADR_IRQ_MSK, 32'h1);
    settle;
    `CHK("irq_unmasked", 1'b1, irq)
    wr(ADR_IRQ_GLB, 32'h0);
    settle;
    `CHK("irq_global", 1'b0, irq)
    $display("test irq done");
    print_verdict;
  end
endmodule
`default_nettype wire
